//--- logic/bfs_map.svh
/*
 Register offsets, field positions, reset values and timing figures of the
 burst and fault supervisor.
 Assumes a 25 MHz system clock and a 4-bit word address on the register port.
*/
`ifndef BFS_MAP_SVH
`define BFS_MAP_SVH
// Register word offsets
`define BFS_REG_MODE 4'h0
`define BFS_REG_BURST 4'h1
`define BFS_REG_OC 4'h2
`define BFS_REG_OT 4'h3
`define BFS_REG_FAST 4'h4
`define BFS_REG_DELAY 4'h5
`define BFS_REG_STATUS 4'h6
`define BFS_REG_IRQ 4'h7
`define BFS_REG_MASK 4'h8
`define BFS_REG_CTRL 4'h9
// Power mode codes
`define BFS_MODE_REGULAR 2'h0
`define BFS_MODE_BURST 2'h3
// Reset values of limits and settings
`define BFS_RST_ITH 8'h07
`define BFS_RST_ERR 8'h08
`define BFS_RST_REPS 2'h0
`define BFS_RST_OC_FAULT 8'h1b
`define BFS_RST_OC_WARN 8'h19
`define BFS_RST_OT_FAULT 8'h7d
`define BFS_RST_OT_WARN 8'h5a
`define BFS_RST_FAST 8'h1e
`define BFS_RST_DELAY_MS 8'h20
// Field positions
`define BFS_CTRL_CLEAR 0
`define BFS_CTRL_DELAYED 1
// Timing
`define BFS_CLOCK_HZ 25000000
`define BFS_RETRY_MS 2
`define BFS_CYCLES_PER_MS (`BFS_CLOCK_HZ / 1000)
`endif

//--- logic/bfs_pkg.sv
/*
 Types shared by the burst and fault supervisor.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package bfs_pkg;
    // Fault handling states, one-hot
    typedef enum logic [4:0] {
        BFS_RUN = 5'h01,
        BFS_DELAY = 5'h02,
        BFS_RETRY = 5'h04,
        BFS_HOLD_OT = 5'h08,
        BFS_LATCHED = 5'h10
    } bfs_fault_type;
    // Burst states, one-hot
    typedef enum logic [3:0] {
        BFS_REGULAR = 4'h1,
        BFS_OFF = 4'h2,
        BFS_POS = 4'h4,
        BFS_NEG = 4'h8
    } bfs_burst_type;
endpackage
`default_nettype wire

//--- logic/bfs_supervisor.sv
/*
 Burst-mode and protection supervisor: gates primary and rectifier drive,
 freezes the duty code in burst, and handles over-current, over-temperature
 and fast-fault shutdown, with a small register port and one interrupt.
 Assumes measurements are codes from same-clock logic; pwm_half is a pulse
 from the modulator ending a half-cycle (pwm_half_pos 1 = positive half just ended).
*/
// Decided for this implementation: the register addresses and the strobed register port.
// Notes on behaviour
// - Burst starts when load current falls below the entry threshold (default 7).
// - Entering burst stops all PWM switching.
// - In burst-off a new burst starts when voltage error reaches the restart threshold.
// - The duty code is frozen at its last value before burst entry.
// - Rectifier drive stays off throughout burst operation.
// - Half-cycles come in full pairs and switches stay off after the last negative half of the burst.
// - Burst repetition selects 1, 2, 4 or 8 cycles, code 0 meaning one.
// - Mode code 0 is regular switching and code 3 enables burst.
// - Each quantity is checked against warning and fault limits and its response applied.
// - Over-current fault stops switching, waits 2 ms and retries once.
// - Over-temperature stops switching and resumes at or below the warning limit.
// - Fast over-current shuts down with no restart.
// - Fast over-current is checked on its own, apart from the normal limit.
// - Delayed response keeps running for a set delay, then shuts down and retries once.
`include "bfs_map.svh"
`default_nettype none
module bfs_supervisor #(
    parameter int MS_CYCLES = `BFS_CYCLES_PER_MS,
    parameter int DUTY_W = 12
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    input wire logic [7:0] load_current,
    input wire logic [7:0] voltage_error,
    input wire logic [7:0] temperature,
    input wire logic [DUTY_W-1:0] duty_in,
    input wire logic pwm_half,
    input wire logic pwm_half_pos,
    output logic [DUTY_W-1:0] duty_out,
    output logic primary_enable,
    output logic rectifier_enable,
    output logic burst_active,
    output logic fault_shutdown,
    output logic irq
);
    initial
    begin
        if (MS_CYCLES < 1 || DUTY_W < 1)
            $error("bfs_supervisor: bad parameter");
    end

    // Register state
    logic [1:0] power_mode, next_power_mode;
    logic [7:0] burst_entry_current_threshold, next_burst_entry_current_threshold;
    logic [7:0] burst_restart_error_threshold, next_burst_restart_error_threshold;
    logic [1:0] burst_reps, next_burst_reps;
    logic [7:0] oc_fault, next_oc_fault, oc_warn, next_oc_warn;
    logic [7:0] ot_fault, next_ot_fault, ot_warn, next_ot_warn;
    logic [7:0] fast_output_overcurrent_limit, next_fast_limit;
    logic [7:0] delay_ms, next_delay_ms;
    logic delayed_resp, next_delayed_resp;
    logic [4:0] irq_status, next_irq_status, irq_mask, next_irq_mask;
    logic [31:0] next_reg_rdata;
    // Engine state
    bfs_pkg::bfs_fault_type fstate, next_fstate;
    bfs_pkg::bfs_burst_type bstate, next_bstate;
    logic [31:0] timer, next_timer;
    logic retry_used, next_retry_used;
    logic [3:0] pairs, next_pairs;
    logic [DUTY_W-1:0] duty_hold, next_duty_hold;
    logic clear_cmd;

    // Number of full cycles per burst
    function automatic logic [3:0] reps_count(input logic [1:0] code);
        reps_count = 4'h1 << code;
    endfunction

    // Warning and fault comparisons
    wire oc_over = load_current > oc_fault;
    wire oc_warning = load_current > oc_warn;
    wire fast_over = load_current > fast_output_overcurrent_limit;
    wire ot_over = temperature > ot_fault;
    wire ot_warning = temperature > ot_warn;
    wire fault_stop = (fstate == bfs_pkg::BFS_RETRY) || (fstate == bfs_pkg::BFS_HOLD_OT)
        || (fstate == bfs_pkg::BFS_LATCHED);
    wire burst_allowed = power_mode == `BFS_MODE_BURST;
    assign clear_cmd = reg_write && reg_addr == `BFS_REG_CTRL && reg_wdata[`BFS_CTRL_CLEAR];

    // Fault response machine; a retry mark set in the clear's cycle wins
    always_comb
    begin
        next_fstate = fstate;
        next_timer = timer;
        next_retry_used = clear_cmd ? 1'b0 : retry_used;
        unique case (fstate)
            bfs_pkg::BFS_RUN:
            begin
                if (fast_over)
                    next_fstate = bfs_pkg::BFS_LATCHED;
                else if (ot_over)
                    next_fstate = bfs_pkg::BFS_HOLD_OT;
                else if (oc_over)
                begin
                    if (retry_used)
                        next_fstate = bfs_pkg::BFS_LATCHED;
                    else if (delayed_resp)
                    begin
                        next_fstate = bfs_pkg::BFS_DELAY;
                        next_timer = 32'(delay_ms) * 32'(MS_CYCLES);
                    end
                    else
                    begin
                        next_fstate = bfs_pkg::BFS_RETRY;
                        next_timer = 32'(`BFS_RETRY_MS) * 32'(MS_CYCLES);
                    end
                end
            end
            bfs_pkg::BFS_DELAY:
            begin
                // Keep switching until the delay runs out, unless a harder fault hits
                if (fast_over)
                    next_fstate = bfs_pkg::BFS_LATCHED;
                else if (ot_over)
                    next_fstate = bfs_pkg::BFS_HOLD_OT;
                else if (timer <= 32'h1)
                begin
                    next_fstate = bfs_pkg::BFS_RETRY;
                    next_timer = 32'(`BFS_RETRY_MS) * 32'(MS_CYCLES);
                end
                else
                    next_timer = timer - 32'h1;
            end
            bfs_pkg::BFS_RETRY:
            begin
                if (timer <= 32'h1)
                begin
                    next_fstate = bfs_pkg::BFS_RUN;
                    next_retry_used = 1'b1;
                end
                else
                    next_timer = timer - 32'h1;
            end
            bfs_pkg::BFS_HOLD_OT:
                if (!ot_warning)
                    next_fstate = bfs_pkg::BFS_RUN;
            bfs_pkg::BFS_LATCHED:
                if (clear_cmd)
                    next_fstate = bfs_pkg::BFS_RUN;
        endcase
    end

    // Burst machine
    always_comb
    begin
        next_bstate = bstate;
        next_pairs = pairs;
        next_duty_hold = duty_hold;
        unique case (bstate)
            bfs_pkg::BFS_REGULAR:
            begin
                next_duty_hold = duty_in;
                if (burst_allowed && !fault_stop
                    && load_current < burst_entry_current_threshold)
                begin
                    next_bstate = bfs_pkg::BFS_OFF;
                end
            end
            bfs_pkg::BFS_OFF:
            begin
                if (!burst_allowed || load_current >= burst_entry_current_threshold)
                begin
                    next_bstate = bfs_pkg::BFS_REGULAR;
                end
                else if (!fault_stop && voltage_error >= burst_restart_error_threshold)
                begin
                    next_bstate = bfs_pkg::BFS_POS;
                    next_pairs = reps_count(burst_reps);
                end
            end
            bfs_pkg::BFS_POS:
                if (pwm_half && pwm_half_pos)
                    next_bstate = bfs_pkg::BFS_NEG;
            bfs_pkg::BFS_NEG:
            begin
                if (pwm_half && !pwm_half_pos)
                begin
                    next_pairs = pairs - 4'h1;
                    next_bstate = (pairs <= 4'h1) ? bfs_pkg::BFS_OFF
                        : bfs_pkg::BFS_POS;
                end
            end
        endcase
    end

    // Register writes and sticky events; a set beats a read clear
    always_comb
    begin
        logic [4:0] events;
        events = {fstate != bfs_pkg::BFS_LATCHED && next_fstate == bfs_pkg::BFS_LATCHED,
                  ot_warning, oc_warning,
                  fstate == bfs_pkg::BFS_RUN && next_fstate != bfs_pkg::BFS_RUN,
                  bstate == bfs_pkg::BFS_REGULAR && next_bstate == bfs_pkg::BFS_OFF};
        next_power_mode = power_mode;
        next_burst_entry_current_threshold = burst_entry_current_threshold;
        next_burst_restart_error_threshold = burst_restart_error_threshold;
        next_burst_reps = burst_reps;
        next_oc_fault = oc_fault;
        next_oc_warn = oc_warn;
        next_ot_fault = ot_fault;
        next_ot_warn = ot_warn;
        next_fast_limit = fast_output_overcurrent_limit;
        next_delay_ms = delay_ms;
        next_delayed_resp = delayed_resp;
        next_irq_mask = irq_mask;
        next_irq_status = irq_status;
        next_reg_rdata = 32'h0;
        if (reg_write)
        begin
            unique case (reg_addr)
                `BFS_REG_MODE: next_power_mode = reg_wdata[1:0];
                `BFS_REG_BURST:
                begin
                    next_burst_entry_current_threshold = reg_wdata[7:0];
                    next_burst_restart_error_threshold = reg_wdata[15:8];
                    next_burst_reps = reg_wdata[17:16];
                end
                `BFS_REG_OC:
                begin
                    next_oc_fault = reg_wdata[7:0];
                    next_oc_warn = reg_wdata[15:8];
                end
                `BFS_REG_OT:
                begin
                    next_ot_fault = reg_wdata[7:0];
                    next_ot_warn = reg_wdata[15:8];
                end
                `BFS_REG_FAST: next_fast_limit = reg_wdata[7:0];
                `BFS_REG_DELAY: next_delay_ms = reg_wdata[7:0];
                `BFS_REG_MASK: next_irq_mask = reg_wdata[4:0];
                `BFS_REG_CTRL: next_delayed_resp = reg_wdata[`BFS_CTRL_DELAYED];
                default: ;
            endcase
        end
        if (reg_read)
        begin
            unique case (reg_addr)
                `BFS_REG_MODE: next_reg_rdata = {30'h0, power_mode};
                `BFS_REG_BURST: next_reg_rdata = {14'h0, burst_reps,
                    burst_restart_error_threshold, burst_entry_current_threshold};
                `BFS_REG_OC: next_reg_rdata = {16'h0, oc_warn, oc_fault};
                `BFS_REG_OT: next_reg_rdata = {16'h0, ot_warn, ot_fault};
                `BFS_REG_FAST: next_reg_rdata = {24'h0, fast_output_overcurrent_limit};
                `BFS_REG_DELAY: next_reg_rdata = {24'h0, delay_ms};
                `BFS_REG_STATUS: next_reg_rdata = {20'h0, retry_used, bstate, fstate,
                    ot_warning, oc_warning};
                `BFS_REG_IRQ:
                begin
                    next_reg_rdata = {27'h0, irq_status};
                    next_irq_status = 5'h0;
                end
                `BFS_REG_MASK: next_reg_rdata = {27'h0, irq_mask};
                `BFS_REG_CTRL: next_reg_rdata = {30'h0, delayed_resp, 1'b0};
                default: next_reg_rdata = 32'h0;
            endcase
        end
        next_irq_status = next_irq_status | events;
    end

    // Register all state
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            power_mode <= `BFS_MODE_REGULAR;
            burst_entry_current_threshold <= `BFS_RST_ITH;
            burst_restart_error_threshold <= `BFS_RST_ERR;
            burst_reps <= `BFS_RST_REPS;
            oc_fault <= `BFS_RST_OC_FAULT;
            oc_warn <= `BFS_RST_OC_WARN;
            ot_fault <= `BFS_RST_OT_FAULT;
            ot_warn <= `BFS_RST_OT_WARN;
            fast_output_overcurrent_limit <= `BFS_RST_FAST;
            delay_ms <= `BFS_RST_DELAY_MS;
            delayed_resp <= 1'b0;
            irq_status <= 5'h0;
            irq_mask <= 5'h0;
            reg_rdata <= 32'h0;
            fstate <= bfs_pkg::BFS_RUN;
            bstate <= bfs_pkg::BFS_REGULAR;
            timer <= 32'h0;
            retry_used <= 1'b0;
            pairs <= 4'h0;
            duty_hold <= '0;
        end
        else
        begin
            power_mode <= next_power_mode;
            burst_entry_current_threshold <= next_burst_entry_current_threshold;
            burst_restart_error_threshold <= next_burst_restart_error_threshold;
            burst_reps <= next_burst_reps;
            oc_fault <= next_oc_fault;
            oc_warn <= next_oc_warn;
            ot_fault <= next_ot_fault;
            ot_warn <= next_ot_warn;
            fast_output_overcurrent_limit <= next_fast_limit;
            delay_ms <= next_delay_ms;
            delayed_resp <= next_delayed_resp;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            reg_rdata <= next_reg_rdata;
            fstate <= next_fstate;
            bstate <= next_bstate;
            timer <= next_timer;
            retry_used <= next_retry_used;
            pairs <= next_pairs;
            duty_hold <= next_duty_hold;
        end
    end

    // Drive gating; fault overrides burst
    wire in_burst = bstate != bfs_pkg::BFS_REGULAR;
    assign burst_active = in_burst;
    assign fault_shutdown = fault_stop;
    assign primary_enable = !fault_stop && (!in_burst || bstate == bfs_pkg::BFS_POS
        || bstate == bfs_pkg::BFS_NEG);
    assign rectifier_enable = !fault_stop && !in_burst;
    assign duty_out = in_burst ? duty_hold : duty_in;
    assign irq = |(irq_status & irq_mask);
endmodule
`default_nettype wire

//--- sim/bfs_checker.sv
/*
 Port-level checks of the burst and fault supervisor.
 Assumes thresholds and fast limit keep their reset values while checked.
*/
`include "bfs_map.svh"
`default_nettype none
module bfs_checker #(
    parameter int MS_CYCLES = 5,
    parameter int DUTY_W = 12
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic [7:0] load_current,
    input wire logic [7:0] voltage_error,
    input wire logic [7:0] temperature,
    input wire logic [DUTY_W-1:0] duty_in,
    input wire logic pwm_half,
    input wire logic pwm_half_pos,
    input wire logic [DUTY_W-1:0] duty_out,
    input wire logic primary_enable,
    input wire logic rectifier_enable,
    input wire logic burst_active,
    input wire logic fault_shutdown,
    input wire logic irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // Burst entry and switching, duty, fault trips and stops, and idle read data
    a_entry_cause: assert property ($rose(burst_active)
        |-> $past(load_current) < `BFS_RST_ITH)
        else $error("burst entered without low load");
    a_entry_halt: assert property ($rose(burst_active) |-> !primary_enable)
        else $error("primary switching at burst entry");
    a_burst_restart: assert property (burst_active && !primary_enable
        && !fault_shutdown && voltage_error >= `BFS_RST_ERR |=> primary_enable || !burst_active)
        else $error("no restart at error threshold");
    a_duty_frozen: assert property (burst_active && $past(burst_active)
        |-> duty_out == $past(duty_out))
        else $error("duty moved during burst");
    a_duty_pass: assert property (!burst_active |-> duty_out == duty_in)
        else $error("duty not passed in regular mode");
    a_rect_off: assert property (burst_active |-> !rectifier_enable)
        else $error("rectifier on in burst");
    a_pair_whole: assert property (burst_active && pwm_half && pwm_half_pos
        ##1 burst_active && !fault_shutdown |-> primary_enable)
        else $error("burst stopped after positive half");
    a_fast_trip: assert property (load_current > `BFS_RST_FAST |-> ##[1:2] fault_shutdown)
        else $error("fast fault missed");
    a_ot_trip: assert property (temperature > `BFS_RST_OT_FAULT
        |-> ##[1:2] fault_shutdown)
        else $error("over-temperature missed");
    a_fault_stop: assert property (fault_shutdown |-> !primary_enable && !rectifier_enable)
        else $error("switching during fault stop");
    a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
        else $error("read data outside read cycle");
    // Main scenarios reached
    c_burst_on: cover property (burst_active && primary_enable);
    c_fault: cover property ($rose(fault_shutdown));
    c_irq: cover property (irq);
endmodule
bind bfs_supervisor bfs_checker #(.MS_CYCLES(MS_CYCLES), .DUTY_W(DUTY_W)) u_bfs_checker (
    .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .load_current(load_current), .voltage_error(voltage_error), .temperature(temperature),
    .duty_in(duty_in), .pwm_half(pwm_half), .pwm_half_pos(pwm_half_pos),
    .duty_out(duty_out), .primary_enable(primary_enable),
    .rectifier_enable(rectifier_enable), .burst_active(burst_active),
    .fault_shutdown(fault_shutdown), .irq(irq));
`default_nettype wire

//--- sim/bfs_stage_model.sv
/*
 Behavioural half-bridge stage and output filter.
 Assumes the supervisor's primary_enable gates all switching.
*/
`default_nettype none
module bfs_stage_model (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic primary_enable,
    output logic pwm_half,
    output logic pwm_half_pos,
    output logic [7:0] voltage_error
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] phase;
    logic pos;
    // Half-cycle end pulse every four cycles, positive half first
    always_ff @(posedge clock)
    begin
        if (!rst_b || !primary_enable)
        begin
            phase <= 2'h0;
            pos <= 1'b1;
            pwm_half <= 1'b0;
        end
        else
        begin
            phase <= phase + 2'h1;
            pwm_half <= (phase == 2'h3);
            if (phase == 2'h3)
                pos <= !pos;
        end
        pwm_half_pos <= pos;
    end
    // Output droops one code a cycle while idle, recovers when switching
    always_ff @(posedge clock)
        if (!rst_b || primary_enable)
            voltage_error <= 8'h00;
        else
            voltage_error <= voltage_error + {7'h0, voltage_error != 8'hff};
endmodule
`default_nettype wire

//--- sim/test_burst_and_fault_supervisor.sv
/*
 Self-checking bench of the burst and fault supervisor.
 Assumes the stage model closes the loop on half-cycles and voltage error.
*/
`include "bfs_map.svh"
`default_nettype none
module test_burst_and_fault_supervisor;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MS = 5;
    typedef struct {logic [3:0] a; logic w; logic [31:0] d; logic [31:0] e;} bfs_row_type;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [31:0] reg_rdata;
    logic [7:0] load_current = 8'h0a;
    logic [7:0] temperature = 8'h19;
    logic [11:0] duty_in = 12'h123;
    logic [7:0] voltage_error;
    logic pwm_half, pwm_half_pos;
    logic [11:0] duty_out;
    logic primary_enable, rectifier_enable, burst_active, fault_shutdown, irq;
    int n_mismatch = 0;
    int check_count = 0;
    bfs_row_type rows[9] = '{
        '{4'h0, 1'b0, 32'h0, 32'h0},
        '{4'h1, 1'b0, 32'h0, {14'h0, `BFS_RST_REPS, `BFS_RST_ERR, `BFS_RST_ITH}},
        '{4'h2, 1'b0, 32'h0, {16'h0, `BFS_RST_OC_WARN, `BFS_RST_OC_FAULT}},
        '{4'h3, 1'b0, 32'h0, {16'h0, `BFS_RST_OT_WARN, `BFS_RST_OT_FAULT}},
        '{4'h4, 1'b0, 32'h0, {24'h0, `BFS_RST_FAST}},
        '{4'h5, 1'b0, 32'h0, {24'h0, `BFS_RST_DELAY_MS}},
        '{4'h6, 1'b0, 32'h0, 32'h84},
        '{4'h8, 1'b1, 32'h1, 32'h1},
        '{4'hf, 1'b1, 32'hffff, 32'h0}};
    always #20 clock = ~clock;
    bfs_supervisor #(.MS_CYCLES(MS), .DUTY_W(12)) u_bfs_supervisor (
        .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .load_current(load_current), .voltage_error(voltage_error),
        .temperature(temperature), .duty_in(duty_in), .pwm_half(pwm_half),
        .pwm_half_pos(pwm_half_pos), .duty_out(duty_out), .primary_enable(primary_enable),
        .rectifier_enable(rectifier_enable), .burst_active(burst_active),
        .fault_shutdown(fault_shutdown), .irq(irq));
    bfs_stage_model u_bfs_stage_model (.clock(clock), .rst_b(rst_b),
        .primary_enable(primary_enable), .pwm_half(pwm_half),
        .pwm_half_pos(pwm_half_pos), .voltage_error(voltage_error));
    // Comparisons and verdict
    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_bit(input string nm, input logic e, input logic g);
        chk_word(nm, {31'h0, e}, {31'h0, g});
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Register port cycles, entered just after a rising edge
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
        @(posedge clock);
    endtask
    // Bounded wait on primary_enable (s=0) or fault_shutdown (s=1)
    task automatic wait_val(input int s, input logic v, input int lim, output int n);
        n = 0;
        #1;
        while ((s == 0 ? primary_enable : fault_shutdown) !== v && n < lim)
        begin
            @(posedge clock);
            #1;
            n++;
        end
    endtask
    // Hang guard
    initial
    begin
        repeat (6000) @(posedge clock);
        n_mismatch++;
        end_sim;
    end
    // Main sequence
    initial
    begin
        int n;
        int halves;
        logic [31:0] got;
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        #1 chk_bit("primary_enable", 1'b1, primary_enable);
        chk_bit("fault_shutdown", 1'b0, fault_shutdown);
        foreach (rows[i])
        begin
            @(posedge clock);
            if (rows[i].w)
                wr(rows[i].a, rows[i].d);
            rd(rows[i].a, got);
            chk_word("reg", rows[i].e, got);
        end
        $display("done registers");
        wr(`BFS_REG_MODE, 32'h3);
        load_current <= 8'h05;
        @(posedge clock);
        @(posedge clock);
        #1 chk_bit("burst_active", 1'b1, burst_active);
        chk_bit("primary_enable", 1'b0, primary_enable);
        chk_bit("rectifier_enable", 1'b0, rectifier_enable);
        chk_bit("irq", 1'b1, irq);
        @(posedge clock);
        duty_in <= 12'h456;
        #1 chk_word("duty_out", 32'h123, {20'h0, duty_out});
        rd(`BFS_REG_IRQ, got);
        chk_word("irq status", 32'h1, got);
        chk_bit("irq", 1'b0, irq);
        for (int r = 0; r < 4; r++)
        begin
            @(posedge clock);
            wr(`BFS_REG_BURST, {14'h0, r[1:0], `BFS_RST_ERR, `BFS_RST_ITH});
            wait_val(0, 1'b0, 100, n);
            wait_val(0, 1'b1, 100, n);
            chk_bit("restart", 1'b1, primary_enable);
            halves = 0;
            for (int t = 0; t < 200 && primary_enable === 1'b1; t++)
            begin
                @(posedge clock);
                #1 halves += int'(pwm_half);
            end
            chk_word("halves", 32'(2 << r), halves);
            chk_bit("idle after pair", 1'b0, primary_enable);
        end
        @(posedge clock);
        wr(`BFS_REG_MODE, 32'h0);
        load_current <= 8'h0a;
        @(posedge clock);
        #1 chk_bit("burst_active", 1'b0, burst_active);
        chk_word("duty_out", 32'h456, {20'h0, duty_out});
        $display("done burst");
        @(posedge clock);
        load_current <= 8'h1c;
        wait_val(1, 1'b1, 4, n);
        chk_bit("oc trip", 1'b1, fault_shutdown);
        @(posedge clock);
        load_current <= 8'h0a;
        wait_val(1, 1'b0, 100, n);
        chk_bit("retry span", 1'b1, n >= 2 * MS - 2 && n <= 2 * MS + 1);
        @(posedge clock);
        load_current <= 8'h1c;
        repeat (4 * MS) @(posedge clock);
        load_current <= 8'h0a;
        #1 chk_bit("second oc latched", 1'b1, fault_shutdown);
        @(posedge clock);
        wr(`BFS_REG_CTRL, 32'h1);
        wait_val(1, 1'b0, 4, n);
        chk_bit("clear", 1'b0, fault_shutdown);
        $display("done overcurrent");
        @(posedge clock);
        wr(`BFS_REG_CTRL, 32'h2);
        load_current <= 8'h1c;
        repeat (32 * MS - 10) @(posedge clock);
        #1 chk_bit("delayed running", 1'b0, fault_shutdown);
        wait_val(1, 1'b1, 30, n);
        chk_bit("delayed stop", 1'b1, fault_shutdown);
        rd(`BFS_REG_STATUS, got);
        chk_word("status", 32'h91, got);
        @(posedge clock);
        load_current <= 8'h0a;
        wait_val(1, 1'b0, 40, n);
        chk_bit("delayed retry", 1'b0, fault_shutdown);
        @(posedge clock);
        wr(`BFS_REG_CTRL, 32'h1);
        @(posedge clock);
        wr(`BFS_REG_OC, {16'h0, `BFS_RST_OC_WARN, 8'hff});
        load_current <= 8'h1f;
        wait_val(1, 1'b1, 4, n);
        chk_bit("fast trip", 1'b1, fault_shutdown);
        @(posedge clock);
        load_current <= 8'h0a;
        repeat (40) @(posedge clock);
        #1 chk_bit("fast latched", 1'b1, fault_shutdown);
        @(posedge clock);
        wr(`BFS_REG_CTRL, 32'h1);
        wait_val(1, 1'b0, 4, n);
        chk_bit("fast clear", 1'b0, fault_shutdown);
        $display("done delayed and fast");
        @(posedge clock);
        wr(`BFS_REG_MODE, 32'h3);
        load_current <= 8'h05;
        temperature <= 8'h7e;
        wait_val(1, 1'b1, 4, n);
        chk_bit("ot trip", 1'b1, fault_shutdown);
        chk_bit("ot primary", 1'b0, primary_enable);
        @(posedge clock);
        temperature <= 8'h64;
        repeat (10) @(posedge clock);
        #1 chk_bit("ot hold", 1'b1, fault_shutdown);
        @(posedge clock);
        temperature <= `BFS_RST_OT_WARN;
        wait_val(1, 1'b0, 4, n);
        chk_bit("ot resume", 1'b0, fault_shutdown);
        $display("done temperature");
        end_sim;
    end
endmodule
`default_nettype wire
